// file: oflc_defines.vh
// constants for the oscillator frequency-lock calibration block
`ifndef OFLC_DEFINES_VH
`define OFLC_DEFINES_VH
`define OFLC_ADDR_W 3
`define OFLC_OFS_CTRL 3'h0
`define OFLC_OFS_FINE 3'h2
`define OFLC_OFS_COARSE 3'h3
`define OFLC_OFS_CMP_LO 3'h4
`define OFLC_OFS_CMP_MID 3'h5
`define OFLC_OFS_CMP_HI 3'h6
`define OFLC_CTRL_EN_BIT 0
`define OFLC_FINE_W 7
`define OFLC_COARSE_W 6
`define OFLC_CMP_W 24
`define OFLC_FINE_MID 7'h40
// 32.0 MHz nominal over a 1.024 kHz reference
`define OFLC_CMP_RESET 24'h007A12
`endif

// file: oflc_ref_edge.v
// reference clock synchroniser and rising edge pulse
`timescale 1ns/100ps
module oflc_ref_edge (
  // clock and reset
  input wire clk,
  input wire reset_n,
  // reference level in, edge pulse out
  input wire ref_in,
  output wire ref_rise
);
  reg sync1_ff;
  reg sync2_ff;
  reg sync3_ff;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      sync3_ff <= 1'b0;
    end else begin
      sync1_ff <= ref_in;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end
  // edge taken only past the second stage
  assign ref_rise = sync2_ff & ~sync3_ff;
endmodule

// file: oflc_top.v
// frequency-locked loop calibrating an internal oscillator against a reference
`timescale 1ns/100ps
`include "oflc_defines.vh"
// What this block does
// - reset clears the six-bit coarse field; the first clock after release loads it from factory data.
// - the loop never modifies the coarse field.
// - coarse writes are ignored while the loop is enabled.
// - compare value is target-to-reference ratio; reset is nominal at 1.024kHz.
// - compare split over three bytes, least significant byte lowest.
// - setting the enable bit starts automatic calibration.
// - full calibration is 13 bits: seven fine plus six coarse.
// - while disabled software writes both fields; oscillator follows them.
module oflc_top #(
  parameter CNT_W = `OFLC_CMP_W
) (
  // clock and reset
  input wire clk,
  input wire reset_n,
  // factory calibration data, sampled at reset release
  input wire [`OFLC_FINE_W-1:0] factory_fine,
  input wire [`OFLC_COARSE_W-1:0] factory_coarse,
  // oscillator cycle pulse and reference clock level
  input wire osc_tick,
  input wire ref_clk,
  // register port
  input wire [`OFLC_ADDR_W-1:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // calibration to the oscillator
  output wire [`OFLC_FINE_W+`OFLC_COARSE_W-1:0] osc_cal
);
  reg en_ff;
  reg [`OFLC_FINE_W-1:0] fine_ff;
  reg [`OFLC_COARSE_W-1:0] coarse_ff;
  reg [`OFLC_CMP_W-1:0] cmp_ff;
  reg [CNT_W-1:0] cnt_ff;
  reg strap_ff;
  reg primed_ff;
  wire ref_rise;
  wire wr_ctrl = reg_wr && (reg_addr == `OFLC_OFS_CTRL);
  wire wr_fine = reg_wr && (reg_addr == `OFLC_OFS_FINE);
  wire wr_coarse = reg_wr && (reg_addr == `OFLC_OFS_COARSE);

  oflc_ref_edge u_ref (
    .clk(clk),
    .reset_n(reset_n),
    .ref_in(ref_clk),
    .ref_rise(ref_rise)
  );

  assign osc_cal = {coarse_ff, fine_ff};

  // factory data caught on the first clock after release
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      strap_ff <= 1'b1;
    else
      strap_ff <= 1'b0;
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      en_ff <= 1'b0;
    else if (wr_ctrl)
      en_ff <= reg_wdata[`OFLC_CTRL_EN_BIT];
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      coarse_ff <= {`OFLC_COARSE_W{1'b0}};
    else if (strap_ff)
      coarse_ff <= factory_coarse;
    else if (wr_coarse && !en_ff)
      coarse_ff <= reg_wdata[`OFLC_COARSE_W-1:0];
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      cmp_ff <= `OFLC_CMP_RESET;
    else if (reg_wr) begin
      case (reg_addr)
        `OFLC_OFS_CMP_LO: cmp_ff[7:0] <= reg_wdata;
        `OFLC_OFS_CMP_MID: cmp_ff[15:8] <= reg_wdata;
        `OFLC_OFS_CMP_HI: cmp_ff[23:16] <= reg_wdata;
        default: cmp_ff <= cmp_ff;
      endcase
    end
  end

  // count oscillator cycles between reference edges
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_ff <= {CNT_W{1'b0}};
      primed_ff <= 1'b0;
    end else if (!en_ff) begin
      cnt_ff <= {CNT_W{1'b0}};
      primed_ff <= 1'b0;
    end else if (ref_rise) begin
      cnt_ff <= {{(CNT_W-1){1'b0}}, osc_tick};
      primed_ff <= 1'b1;
    end else if (osc_tick && (cnt_ff != {CNT_W{1'b1}}))
      cnt_ff <= cnt_ff + 1'b1;
  end

  // fine field: factory, software, or loop step
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      fine_ff <= {`OFLC_FINE_W{1'b0}};
    else if (strap_ff)
      fine_ff <= factory_fine;
    else if (!en_ff) begin
      if (wr_fine)
        fine_ff <= reg_wdata[`OFLC_FINE_W-1:0];
    // step by one, saturating at the ends
    end else if (ref_rise && primed_ff) begin
      if (cnt_ff < cmp_ff[CNT_W-1:0] && fine_ff != {`OFLC_FINE_W{1'b1}})
        fine_ff <= fine_ff + 1'b1;
      else if (cnt_ff > cmp_ff[CNT_W-1:0] && fine_ff != {`OFLC_FINE_W{1'b0}})
        fine_ff <= fine_ff - 1'b1;
    end
  end

  // read data one cycle after the strobe; reserved bits read zero
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      reg_rdata <= 8'h00;
    else if (reg_rd) begin
      case (reg_addr)
        `OFLC_OFS_CTRL: reg_rdata <= {7'h00, en_ff};
        `OFLC_OFS_FINE: reg_rdata <= {1'b0, fine_ff};
        `OFLC_OFS_COARSE: reg_rdata <= {2'b00, coarse_ff};
        `OFLC_OFS_CMP_LO: reg_rdata <= cmp_ff[7:0];
        `OFLC_OFS_CMP_MID: reg_rdata <= cmp_ff[15:8];
        `OFLC_OFS_CMP_HI: reg_rdata <= cmp_ff[23:16];
        default: reg_rdata <= 8'h00;
      endcase
    end else
      reg_rdata <= 8'h00;
  end
endmodule

// file: oflc_assertions.sv
// port assertions for the calibration block
`timescale 1ns/100ps
module oflc_chk(
  // clock and reset
  input wire clk,
  input wire reset_n,
  // register port and calibration
  input wire [2:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire [12:0] osc_cal
);
  reg en_ff;
  always @(posedge clk or negedge reset_n)
    if (!reset_n) en_ff <= 1'b0;
    else if (reg_wr && reg_addr == 3'h0) en_ff <= reg_wdata[0];
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  AST_COARSE_HOLD: assert property (
    en_ff |=> $stable(osc_cal[12:7])) else $error("coarse moved");
  AST_FINE_STEP: assert property (
    en_ff |=> (osc_cal[6:0] - $past(osc_cal[6:0])) inside {7'h0, 7'h1, 7'h7F})
    else $error("fine jump");
  AST_RD_IDLE: assert property (
    !$past(reg_rd) |-> reg_rdata == 8'h00) else $error("rdata idle");
  AST_RD_CTRL: assert property (
    reg_rd && reg_addr == 3'h0 |=> reg_rdata == {7'h00, en_ff}) else $error("ctrl read");
  AST_RD_FINE: assert property (
    reg_rd && reg_addr == 3'h2 |=> reg_rdata == {1'b0, $past(osc_cal[6:0])})
    else $error("fine read");
  AST_RD_COARSE: assert property (
    reg_rd && reg_addr == 3'h3 |=> reg_rdata == {2'b00, $past(osc_cal[12:7])})
    else $error("coarse read");
  AST_MAN_FINE: assert property (
    reg_wr && reg_addr == 3'h2 && !en_ff |=> osc_cal[6:0] == $past(reg_wdata[6:0]))
    else $error("fine write");
  AST_MAN_COARSE: assert property (
    reg_wr && reg_addr == 3'h3 && !en_ff |=> osc_cal[12:7] == $past(reg_wdata[5:0]))
    else $error("coarse write");
endmodule
bind oflc_top oflc_chk u_chk(.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .osc_cal(osc_cal));

// file: tb.sv
// self-checking bench for the calibration block
`timescale 1ns/100ps
module tb;
  reg clk = 0, reset_n = 0, ref_clk = 0, reg_wr = 0, reg_rd = 0, rd_d = 0;
  reg [6:0] ff = 0;
  reg [5:0] fc = 0;
  reg [2:0] reg_addr = 0;
  reg [7:0] reg_wdata = 0;
  reg [31:0] sd = 21;
  // separate stream so tick draws never disturb the stored expectations
  reg [31:0] tsd = 21;
  reg tick = 0;
  reg [7:0] exp_q[$];
  wire [7:0] reg_rdata;
  wire [12:0] osc_cal;
  integer error_cnt = 0, check_count = 0;
  always #2.5 clk = ~clk;
  oflc_top DUT(.clk(clk), .reset_n(reset_n), .factory_fine(ff), .factory_coarse(fc),
    .osc_tick(tick), .ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .osc_cal(osc_cal));
  function [31:0] xs(input [31:0] x);
    xs = x ^ (x << 13);
    xs = xs ^ (xs >> 17);
    xs = xs ^ (xs << 5);
  endfunction
  task chk(input [7:0] s, input [7:0] e);
    check_count++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch %0t %h %h", $time, s, e);
    end
  endtask
  task summarize;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // strobes stay up between calls so no signal is assigned twice per step
  task wr(input [2:0] a, input [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_rd <= 0;
    reg_wr <= 1;
    @(posedge clk);
  endtask
  task rd(input [2:0] a, input [7:0] e);
    reg_addr <= a;
    reg_wr <= 0;
    reg_rd <= 1;
    exp_q.push_back(e);
    @(posedge clk);
  endtask
  // n reference periods of 40 cycles, ticks from the random tick stream
  task refs(input integer n);
    reg_wr <= 0;
    reg_rd <= 0;
    repeat (n) begin
      repeat (20) @(posedge clk);
      ref_clk <= 1;
      repeat (20) @(posedge clk);
      ref_clk <= 0;
    end
    repeat (5) @(posedge clk);
  endtask
  // random oscillator ticks; a period count stays far below 0x7A12 and above zero
  always @(posedge clk) begin
    tsd <= xs(tsd);
    tick <= tsd[3];
  end
  always @(posedge clk) begin
    if (rd_d)
      chk(reg_rdata, exp_q.pop_front());
    rd_d <= reg_rd;
  end
  initial begin
    #50000;
    error_cnt++;
    summarize;
  end
  initial begin
    sd = xs(sd);
    ff = sd[6:0];
    fc = sd[13:8];
    repeat (20) @(posedge clk);
    reset_n <= 1;
    repeat (2) @(posedge clk);
    rd(3'h2, {1'b0, ff});
    rd(3'h3, {2'b00, fc});
    rd(3'h4, 8'h12);
    rd(3'h5, 8'h7A);
    rd(3'h6, 8'h00);
    rd(3'h1, 8'h00);
    sd = xs(sd);
    wr(3'h3, {2'b00, sd[5:0]});
    wr(3'h2, 8'h40);
    wr(3'h0, 8'h01);
    wr(3'h3, {2'b00, ~sd[5:0]});
    rd(3'h0, 8'h01);
    rd(3'h3, {2'b00, sd[5:0]});
    refs(4);
    rd(3'h2, 8'h43);
    wr(3'h0, 8'h00);
    rd(3'h0, 8'h00);
    wr(3'h4, 8'h00);
    wr(3'h5, 8'h00);
    wr(3'h0, 8'h01);
    refs(4);
    rd(3'h2, 8'h40);
    rd(3'h3, {2'b00, sd[5:0]});
    refs(0);
    #1;
    chk({1'b0, osc_cal[6:0]}, 8'h40);
    chk({2'b00, osc_cal[12:7]}, {2'b00, sd[5:0]});
    summarize;
  end
endmodule
